// *** core/fsled_check.sv ***
`timescale 1ns/1ns
// ============================================================================
// Combinational decode of one leaf entry against one request.
// ============================================================================
module fsled_check #(
  parameter int HOST_ADDR_WIDTH = fsled_pkg::HOST_ADDR_WIDTH_DEF
) (
  // Entry and governing controls.
  input wire logic [63:0] entry_i,
  input wire logic exec_disable_enable_i,
  input wire logic supervisor_write_protect_i,
  input wire logic coherent_domain_i,
  // Request attributes.
  input wire logic req_write_i,
  input wire logic req_user_i,
  input wire logic req_exec_i,
  // Decode results.
  output fsled_pkg::fsled_fault_t fault_o,
  output logic [63:0] page_addr_o,
  output logic [2:0] mem_attr_o
);

  logic [63:0] rsvd_mask;
  logic [63:0] addr_mask;
  logic write_ok;

  always_comb begin
    rsvd_mask = 64'h0;
    addr_mask = 64'h0;
    for (int i = fsled_pkg::ENT_ADDR_LSB; i <= fsled_pkg::ENT_RSVD_TOP; i++) begin
      if (i >= HOST_ADDR_WIDTH) begin
        rsvd_mask[i] = 1'b1;
      end else begin
        addr_mask[i] = 1'b1;
      end
    end
  end

  // The global flag is never looked at, so it acts as if clear.
  assign page_addr_o = entry_i & addr_mask;

  // Memory type index only matters for coherent devices; others see zero.
  assign mem_attr_o = coherent_domain_i ? {entry_i[fsled_pkg::ENT_ATTR_INDEX],
                                           entry_i[fsled_pkg::ENT_CACHE_INHIBIT],
                                           entry_i[fsled_pkg::ENT_WRITE_THROUGH]} : 3'h0;

  always_comb begin
    write_ok = entry_i[fsled_pkg::ENT_WRITE] ||
               (!req_user_i && !supervisor_write_protect_i);
    if (!entry_i[fsled_pkg::ENT_PRESENT]) begin
      fault_o = fsled_pkg::FSLED_FAULT_NOT_PRESENT;
    end else if ((entry_i & rsvd_mask) != 64'h0) begin
      fault_o = fsled_pkg::FSLED_FAULT_RESERVED;
    end else if (req_user_i && !entry_i[fsled_pkg::ENT_USER]) begin
      fault_o = fsled_pkg::FSLED_FAULT_USER;
    end else if (req_write_i && !write_ok) begin
      fault_o = fsled_pkg::FSLED_FAULT_WRITE;
    end else if (req_exec_i && exec_disable_enable_i && entry_i[fsled_pkg::ENT_EXEC_BLOCK]) begin
      fault_o = fsled_pkg::FSLED_FAULT_EXEC;
    end else begin
      fault_o = fsled_pkg::FSLED_FAULT_NONE;
    end
  end

endmodule : fsled_check

// *** core/fsled_pkg.sv ***
package fsled_pkg;

  // ==========================================================================
  // Leaf entry field positions.
  // ==========================================================================
  localparam int ENT_EXEC_BLOCK = 63;
  localparam int ENT_RSVD_TOP = 51;
  localparam int ENT_ADDR_LSB = 12;
  localparam int ENT_EXT_USED = 10;
  localparam int ENT_GLOBAL = 8;
  localparam int ENT_ATTR_INDEX = 7;
  localparam int ENT_DIRTY = 6;
  localparam int ENT_USED = 5;
  localparam int ENT_CACHE_INHIBIT = 4;
  localparam int ENT_WRITE_THROUGH = 3;
  localparam int ENT_USER = 2;
  localparam int ENT_WRITE = 1;
  localparam int ENT_PRESENT = 0;
  localparam int HOST_ADDR_WIDTH_DEF = 48;

  // ==========================================================================
  // Register offsets (byte addresses, one word each).
  // ==========================================================================
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INT_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_MASK = 8'h08;
  localparam logic [7:0] OFS_FAULT_INFO = 8'h0c;
  localparam logic [7:0] OFS_XLATE_COUNT = 8'h10;
  localparam logic [7:0] OFS_LAST_ADDR_LO = 8'h14;
  localparam logic [7:0] OFS_LAST_ADDR_HI = 8'h18;

  // ==========================================================================
  // Control register fields and reset value.
  // ==========================================================================
  localparam int CTRL_EXEC_DISABLE_ENABLE = 0;
  localparam int CTRL_EXTENDED_USED_ENABLE = 1;
  localparam int CTRL_SUPERVISOR_WRITE_PROTECT = 2;
  localparam int CTRL_COHERENT_DOMAIN = 3;
  localparam int CTRL_TTYPE_LSB = 4;
  localparam int CTRL_ENABLE = 7;
  localparam int CTRL_WIDTH = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] TTYPE_NESTED = 3'h3;

  // ==========================================================================
  // Interrupt status bits.
  // ==========================================================================
  localparam int INT_XLATED = 0;
  localparam int INT_FAULT = 1;
  localparam int INT_ENTRY_UPDATE = 2;
  localparam int INT_WIDTH = 3;
  localparam logic [2:0] INT_RESET = 3'h0;

  typedef enum logic [2:0] {
    FSLED_FAULT_NONE = 3'b000,
    FSLED_FAULT_NOT_PRESENT = 3'b001,
    FSLED_FAULT_RESERVED = 3'b010,
    FSLED_FAULT_USER = 3'b011,
    FSLED_FAULT_WRITE = 3'b100,
    FSLED_FAULT_EXEC = 3'b101
  } fsled_fault_t;

endpackage : fsled_pkg

// *** core/fsled_top.sv ***
`timescale 1ns/1ns
module fsled_top #(
  parameter int HOST_ADDR_WIDTH = fsled_pkg::HOST_ADDR_WIDTH_DEF
) (
  // Clock, reset and clock enable.
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Translation request with the fetched leaf entry.
  input wire logic req_valid_i,
  input wire logic [63:0] req_entry_i,
  input wire logic req_write_i,
  input wire logic req_user_i,
  input wire logic req_exec_i,
  // Translation response.
  output logic rsp_valid_o,
  output logic rsp_fault_o,
  output logic [2:0] rsp_fault_cause_o,
  output logic [63:0] rsp_addr_o,
  output logic rsp_guest_phys_addr_o,
  output logic [2:0] rsp_mem_attr_o,
  // Entry write-back towards the table in memory.
  output logic wb_valid_o,
  output logic [63:0] wb_entry_o,
  // Interrupt.
  output logic irq_o
);

  // ==========================================================================
  // Register state.
  // ==========================================================================
  logic [fsled_pkg::CTRL_WIDTH-1:0] ctrl_reg;
  logic [fsled_pkg::CTRL_WIDTH-1:0] ctrl_next;
  logic [fsled_pkg::INT_WIDTH-1:0] int_status_reg;
  logic [fsled_pkg::INT_WIDTH-1:0] int_status_next;
  logic [fsled_pkg::INT_WIDTH-1:0] int_mask_reg;
  logic [fsled_pkg::INT_WIDTH-1:0] int_mask_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // ==========================================================================
  // Translation state.
  // ==========================================================================
  logic rsp_valid_reg;
  logic rsp_valid_next;
  logic rsp_fault_reg;
  logic rsp_fault_next;
  logic [2:0] rsp_cause_reg;
  logic [2:0] rsp_cause_next;
  logic [63:0] rsp_addr_reg;
  logic [63:0] rsp_addr_next;
  logic rsp_guest_reg;
  logic rsp_guest_next;
  logic [2:0] rsp_attr_reg;
  logic [2:0] rsp_attr_next;
  logic wb_valid_reg;
  logic wb_valid_next;
  logic [63:0] wb_entry_reg;
  logic [63:0] wb_entry_next;
  logic [2:0] last_cause_reg;
  logic [2:0] last_cause_next;
  logic [31:0] xlate_count_reg;
  logic [31:0] xlate_count_next;

  fsled_pkg::fsled_fault_t chk_fault;
  logic [63:0] chk_addr;
  logic [2:0] chk_attr;
  logic take;
  logic ok;
  logic [63:0] upd_entry;
  logic [fsled_pkg::INT_WIDTH-1:0] events;

  // Extracts one control bit; used by several decode points.
  function automatic logic ctrl_bit(input logic [fsled_pkg::CTRL_WIDTH-1:0] c, input int pos);
    ctrl_bit = c[pos];
  endfunction : ctrl_bit

  // ==========================================================================
  // Entry decode.
  // ==========================================================================
  fsled_check #(
    .HOST_ADDR_WIDTH(HOST_ADDR_WIDTH)
  ) u_check (
    .entry_i(req_entry_i),
    .exec_disable_enable_i(ctrl_bit(ctrl_reg, fsled_pkg::CTRL_EXEC_DISABLE_ENABLE)),
    .supervisor_write_protect_i(ctrl_bit(ctrl_reg, fsled_pkg::CTRL_SUPERVISOR_WRITE_PROTECT)),
    .coherent_domain_i(ctrl_bit(ctrl_reg, fsled_pkg::CTRL_COHERENT_DOMAIN)),
    .req_write_i(req_write_i),
    .req_user_i(req_user_i),
    .req_exec_i(req_exec_i),
    .fault_o(chk_fault),
    .page_addr_o(chk_addr),
    .mem_attr_o(chk_attr)
  );

  // ==========================================================================
  // Request acceptance and entry update.
  // ==========================================================================
  always_comb begin
    take = req_valid_i && ctrl_bit(ctrl_reg, fsled_pkg::CTRL_ENABLE);
    ok = take && (chk_fault == fsled_pkg::FSLED_FAULT_NONE);
    upd_entry = req_entry_i;
    upd_entry[fsled_pkg::ENT_USED] = 1'b1;
    if (ctrl_bit(ctrl_reg, fsled_pkg::CTRL_EXTENDED_USED_ENABLE)) begin
      upd_entry[fsled_pkg::ENT_EXT_USED] = 1'b1;
    end
    // The update is only used on a granted request, so a refused write never marks the page dirty.
    if (req_write_i) begin
      upd_entry[fsled_pkg::ENT_DIRTY] = 1'b1;
    end
  end

  // ==========================================================================
  // Response next state.
  // ==========================================================================
  // A refused request reports only its cause; address and attributes read as zero.
  always_comb begin
    rsp_valid_next = take;
    rsp_fault_next = rsp_fault_reg;
    rsp_cause_next = rsp_cause_reg;
    rsp_addr_next = rsp_addr_reg;
    rsp_guest_next = rsp_guest_reg;
    rsp_attr_next = rsp_attr_reg;
    if (take) begin
      rsp_fault_next = !ok;
      rsp_cause_next = chk_fault;
      rsp_addr_next = ok ? chk_addr : 64'h0;
      rsp_guest_next = ok && (ctrl_reg[fsled_pkg::CTRL_TTYPE_LSB +: 3] == fsled_pkg::TTYPE_NESTED);
      rsp_attr_next = ok ? chk_attr : 3'h0;
    end
  end

  // ==========================================================================
  // Write-back next state.
  // ==========================================================================
  always_comb begin
    wb_valid_next = 1'b0;
    wb_entry_next = wb_entry_reg;
    // Memory is only written when a flag really changes, to save bus traffic.
    if (ok && (upd_entry != req_entry_i)) begin
      wb_valid_next = 1'b1;
      wb_entry_next = upd_entry;
    end
  end

  // ==========================================================================
  // Statistics next state.
  // ==========================================================================
  always_comb begin
    last_cause_next = last_cause_reg;
    xlate_count_next = xlate_count_reg;
    if (take) begin
      last_cause_next = chk_fault;
    end
    // The count wraps silently; software treats it as a free-running total.
    if (ok) begin
      xlate_count_next = xlate_count_reg + 32'h1;
    end
  end

  // ==========================================================================
  // Register next state.
  // ==========================================================================
  always_comb begin
    events = '0;
    events[fsled_pkg::INT_XLATED] = ok;
    events[fsled_pkg::INT_FAULT] = take && !ok;
    events[fsled_pkg::INT_ENTRY_UPDATE] = wb_valid_next;
    ctrl_next = ctrl_reg;
    int_mask_next = int_mask_reg;
    int_status_next = int_status_reg;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        fsled_pkg::OFS_CTRL: begin
          ctrl_next = reg_wdata_i[fsled_pkg::CTRL_WIDTH-1:0];
        end
        fsled_pkg::OFS_INT_MASK: begin
          int_mask_next = reg_wdata_i[fsled_pkg::INT_WIDTH-1:0];
        end
        fsled_pkg::OFS_INT_STATUS: begin
          int_status_next = int_status_reg & ~reg_wdata_i[fsled_pkg::INT_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end
    // A new event wins over a clear written in the same cycle.
    int_status_next = int_status_next | events;
  end

  // ==========================================================================
  // Read data next state.
  // ==========================================================================
  always_comb begin
    rdata_next = 32'h0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        fsled_pkg::OFS_CTRL: rdata_next = {24'h0, ctrl_reg};
        fsled_pkg::OFS_INT_STATUS: rdata_next = {29'h0, int_status_reg};
        fsled_pkg::OFS_INT_MASK: rdata_next = {29'h0, int_mask_reg};
        fsled_pkg::OFS_FAULT_INFO: rdata_next = {29'h0, last_cause_reg};
        fsled_pkg::OFS_XLATE_COUNT: rdata_next = xlate_count_reg;
        fsled_pkg::OFS_LAST_ADDR_LO: rdata_next = rsp_addr_reg[31:0];
        fsled_pkg::OFS_LAST_ADDR_HI: rdata_next = rsp_addr_reg[63:32];
        default: rdata_next = 32'h0;
      endcase
    end
  end

  // ==========================================================================
  // Register group.
  // ==========================================================================
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_reg <= fsled_pkg::CTRL_RESET;
      int_status_reg <= fsled_pkg::INT_RESET;
      int_mask_reg <= fsled_pkg::INT_RESET;
      rdata_reg <= 32'h0;
    end else if (ce_i) begin
      ctrl_reg <= ctrl_next;
      int_status_reg <= int_status_next;
      int_mask_reg <= int_mask_next;
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================================
  // Response group.
  // ==========================================================================
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rsp_valid_reg <= 1'b0;
      rsp_fault_reg <= 1'b0;
      rsp_cause_reg <= 3'h0;
      rsp_addr_reg <= 64'h0;
      rsp_guest_reg <= 1'b0;
      rsp_attr_reg <= 3'h0;
    end else if (ce_i) begin
      rsp_valid_reg <= rsp_valid_next;
      rsp_fault_reg <= rsp_fault_next;
      rsp_cause_reg <= rsp_cause_next;
      rsp_addr_reg <= rsp_addr_next;
      rsp_guest_reg <= rsp_guest_next;
      rsp_attr_reg <= rsp_attr_next;
    end
  end

  // ==========================================================================
  // Write-back group.
  // ==========================================================================
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_valid_reg <= 1'b0;
      wb_entry_reg <= 64'h0;
    end else if (ce_i) begin
      wb_valid_reg <= wb_valid_next;
      wb_entry_reg <= wb_entry_next;
    end
  end

  // ==========================================================================
  // Statistics group.
  // ==========================================================================
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_cause_reg <= 3'h0;
      xlate_count_reg <= 32'h0;
    end else if (ce_i) begin
      last_cause_reg <= last_cause_next;
      xlate_count_reg <= xlate_count_next;
    end
  end

  // ==========================================================================
  // Outputs.
  // ==========================================================================
  assign reg_rdata_o = rdata_reg;
  assign rsp_valid_o = rsp_valid_reg;
  assign rsp_fault_o = rsp_fault_reg;
  assign rsp_fault_cause_o = rsp_cause_reg;
  assign rsp_addr_o = rsp_addr_reg;
  assign rsp_guest_phys_addr_o = rsp_guest_reg;
  assign rsp_mem_attr_o = rsp_attr_reg;
  assign wb_valid_o = wb_valid_reg;
  assign wb_entry_o = wb_entry_reg;
  assign irq_o = |(int_status_reg & int_mask_reg);

endmodule : fsled_top

// *** test/fsled_table_model.sv ***
`timescale 1ns/1ns
// ========================================================
// One table entry in memory, updated by write-backs.
// ========================================================
module fsled_table_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic resetn_i,
  // Software side.
  input wire logic load_i,
  input wire logic [63:0] load_entry_i,
  // Decoder side.
  input wire logic wb_valid_i,
  input wire logic [63:0] wb_entry_i,
  output logic [63:0] entry_o
);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      entry_o <= 64'h0;
    end else if (load_i) begin
      entry_o <= load_entry_i;
    end else if (wb_valid_i) begin
      entry_o <= wb_entry_i;
    end
  end
endmodule : fsled_table_model

// *** test/fsled_top_monitor.sv ***
`timescale 1ns/1ns
// ========================================================
// Port checker for the leaf entry decoder.
// ========================================================
module fsled_top_monitor #(
  parameter int HOST_ADDR_WIDTH = fsled_pkg::HOST_ADDR_WIDTH_DEF
) (
  // Clock and request side.
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic req_valid_i,
  input wire logic [63:0] req_entry_i,
  input wire logic req_write_i,
  input wire logic req_user_i,
  // Response side.
  input wire logic rsp_valid_o,
  input wire logic rsp_fault_o,
  input wire logic [2:0] rsp_fault_cause_o,
  input wire logic [63:0] rsp_addr_o,
  input wire logic wb_valid_o,
  input wire logic [63:0] wb_entry_o,
  input wire logic irq_o
);
  localparam logic [63:0] AMASK = ((64'h1 << HOST_ADDR_WIDTH) - 64'h1) & ~64'hfff;
  // The capture freezes with ce_i, as the design does, so a held response still matches it.
  logic [65:0] cap_reg;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cap_reg <= '0;
    end else if (ce_i) begin
      cap_reg <= {req_write_i, req_user_i, req_entry_i};
    end
  end
  wire logic [63:0] ent = cap_reg[63:0];
  wire logic usr = cap_reg[64];
  wire logic wr = cap_reg[65];
  wire logic rsvd = |(ent[51:0] >> HOST_ADDR_WIDTH);
  wire logic ok = rsp_valid_o && !rsp_fault_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  absent_entry_a: assert property (rsp_valid_o && !ent[0] |-> rsp_fault_o && rsp_fault_cause_o == 3'h1)
    else $error("absent entry not refused");
  reserved_bits_a: assert property (rsp_valid_o && ent[0] && rsvd |-> rsp_fault_cause_o == 3'h2)
    else $error("reserved bits not faulted");
  user_refused_a: assert property (ok && usr |-> ent[2])
    else $error("user request granted");
  user_write_a: assert property (ok && usr && wr |-> ent[1])
    else $error("user write granted");
  frame_addr_a: assert property (ok |-> rsp_addr_o == (ent & AMASK))
    else $error("frame address wrong");
  addr_hold_a: assert property (!rsp_valid_o |-> $stable(rsp_addr_o))
    else $error("address changed without response");
  used_flag_a: assert property (wb_valid_o |-> ok && wb_entry_o[5])
    else $error("used flag not written");
  dirty_flag_a: assert property (wb_valid_o |-> wb_entry_o[6] == (ent[6] || wr))
    else $error("dirty flag wrong");
  wb_keep_a: assert property (wb_valid_o |-> (wb_entry_o & ~64'h460) == (ent & ~64'h460))
    else $error("write-back altered other bits");
  cover property (wb_valid_o && wb_entry_o[6]);
  cover property (rsp_valid_o && rsp_fault_o);
  cover property (irq_o);
endmodule : fsled_top_monitor

bind fsled_top fsled_top_monitor #(.HOST_ADDR_WIDTH(HOST_ADDR_WIDTH)) u_monitor (
  .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
  .req_valid_i(req_valid_i), .req_entry_i(req_entry_i), .req_write_i(req_write_i), .req_user_i(req_user_i),
  .rsp_valid_o(rsp_valid_o), .rsp_fault_o(rsp_fault_o), .rsp_fault_cause_o(rsp_fault_cause_o),
  .rsp_addr_o(rsp_addr_o), .wb_valid_o(wb_valid_o), .wb_entry_o(wb_entry_o), .irq_o(irq_o));

// *** test/fsled_top_test.sv ***
`timescale 1ns/1ns
module fsled_top_test;
  localparam int HOST_ADDR_WIDTH = 40;
  localparam logic [63:0] AM = ((64'h1 << HOST_ADDR_WIDTH) - 64'h1) & ~64'hfff;
  logic clk, resetn, ce, reg_wr, reg_rd, req_valid, req_write, req_user, req_exec, load;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [63:0] load_e;
  wire logic [31:0] rdata;
  wire logic rv, rf, guest_phys, wbv, irq;
  wire logic [2:0] cause, attr;
  wire logic [63:0] raddr, wbe, ent;
  int errors = 0;
  int n_checks = 0;
  fsled_top #(.HOST_ADDR_WIDTH(HOST_ADDR_WIDTH)) u_dut (.clk_i(clk), .resetn_i(resetn), .ce_i(ce),
    .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .req_valid_i(req_valid),
    .req_entry_i(ent), .req_write_i(req_write), .req_user_i(req_user), .req_exec_i(req_exec), .rsp_valid_o(rv),
    .rsp_fault_o(rf), .rsp_fault_cause_o(cause), .rsp_addr_o(raddr), .rsp_guest_phys_addr_o(guest_phys),
    .rsp_mem_attr_o(attr), .wb_valid_o(wbv), .wb_entry_o(wbe), .irq_o(irq));
  fsled_table_model u_mem (.clk_i(clk), .resetn_i(resetn), .load_i(load), .load_entry_i(load_e),
    .wb_valid_i(wbv), .wb_entry_i(wbe), .entry_o(ent));
  task automatic close_out;
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 cmp(n, {32'h0, e}, {32'h0, rdata});
  endtask : rd
  // Outputs of the response are settled when this returns.
  task automatic xl(input logic [63:0] e, input logic w, input logic u, input logic x);
    @(posedge clk);
    load <= 1'b1;
    load_e <= e;
    @(posedge clk);
    load <= 1'b0;
    req_valid <= 1'b1;
    req_write <= w;
    req_user <= u;
    req_exec <= x;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
  endtask : xl
  task automatic chk(input logic [31:0] c, input logic [63:0] e, input logic w, u, x, input logic [2:0] k);
    wr(8'h00, c);
    xl(e, w, u, x);
    cmp("cause", {61'h0, k}, {61'h0, cause});
    cmp("fault", {63'h0, k != 3'h0}, {63'h0, rf});
  endtask : chk
  task automatic t_regs;
    rd(8'h00, 32'h0, "ctrl reset");
    rd(8'h04, 32'h0, "status reset");
    rd(8'h08, 32'h0, "mask reset");
    wr(8'hfc, 32'hffffffff);
    rd(8'hfc, 32'h0, "unmapped");
    xl(64'h3, 1'b0, 1'b0, 1'b0);
    cmp("disabled rsp", 64'h0, {63'h0, rv});
    wr(8'h00, 32'hff);
    rd(8'h00, 32'hff, "ctrl");
  endtask : t_regs
  task automatic t_write;
    logic [63:0] e;
    e = 64'h0000_00ab_cdef_5107;
    wr(8'h08, 32'h4);
    wr(8'h00, 32'h82);
    xl(e, 1'b1, 1'b1, 1'b0);
    cmp("rsp valid", 64'h1, {63'h0, rv});
    cmp("rsp addr", e & AM, raddr);
    cmp("wb entry", e | 64'h460, wbe);
    cmp("irq", 64'h1, {63'h0, irq});
    xl(e | 64'h460, 1'b1, 1'b1, 1'b0);
    cmp("wb again", 64'h0, {63'h0, wbv});
    rd(8'h04, 32'h5, "status");
    wr(8'h04, 32'h4);
    rd(8'h04, 32'h1, "status cleared");
    cmp("irq cleared", 64'h0, {63'h0, irq});
    rd(8'h10, 32'h2, "count");
    rd(8'h18, 32'hab, "addr hi");
    wr(8'h00, 32'h80);
    xl(64'h3, 1'b0, 1'b0, 1'b0);
    cmp("wb no ext", 64'h23, wbe);
  endtask : t_write
  task automatic t_attr;
    wr(8'h00, 32'hb8);
    xl(64'h89, 1'b0, 1'b0, 1'b0);
    cmp("attr", 64'h5, {61'h0, attr});
    cmp("guest", 64'h1, {63'h0, guest_phys});
    wr(8'h00, 32'h90);
    xl(64'h89, 1'b0, 1'b0, 1'b0);
    cmp("attr off", 64'h0, {61'h0, attr});
    cmp("guest off", 64'h0, {63'h0, guest_phys});
  endtask : t_attr
  // A write strobe seen while the clock enable is low must leave the mask as it was.
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    wr(8'h08, 32'h7);
    @(posedge clk);
    ce <= 1'b1;
    rd(8'h08, 32'h4, "mask frozen");
  endtask : t_freeze
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #2000000;
    errors = errors + 1;
    close_out();
  end
  initial begin
    {resetn, reg_wr, reg_rd, req_valid, req_write, req_user, req_exec, load} = '0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    load_e = 64'h0;
    ce = 1'b1;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_write();
    t_attr();
    t_freeze();
    chk(32'h80, 64'h2, 1'b0, 1'b0, 1'b0, 3'h1);
    chk(32'h80, 64'h3 | (64'h1 << HOST_ADDR_WIDTH), 1'b0, 1'b0, 1'b0, 3'h2);
    chk(32'h80, 64'h3, 1'b0, 1'b1, 1'b0, 3'h3);
    chk(32'h80, 64'h5, 1'b1, 1'b1, 1'b0, 3'h4);
    chk(32'h84, 64'h5, 1'b1, 1'b0, 1'b0, 3'h4);
    chk(32'h80, 64'h5, 1'b1, 1'b0, 1'b0, 3'h0);
    chk(32'h81, 64'h8000_0000_0000_0003, 1'b0, 1'b0, 1'b1, 3'h5);
    chk(32'h80, 64'h8000_0000_0000_0003, 1'b0, 1'b0, 1'b1, 3'h0);
    close_out();
  end
endmodule : fsled_top_test
